// ==== logic/urf_core.sv ====
`timescale 1ns/100ps
`include "urf_params.svh"

// Function
// [RULE_01] Thirty-two 32-bit integer operand registers
// [RULE_02] All user registers 32 bits, no float
// [RULE_03] Condition flags: eight 4-bit fields, msb first
// [RULE_04] Field bits: lt, gt, eq, summary overflow
// [RULE_05] Masked field move from a register
// [RULE_06] Exception top nibble into one field
// [RULE_07] Copy one field into another
// [RULE_08] Bit logic touches only target bit
// [RULE_09] Compare may target any field
// [RULE_10] Branch tests a selected condition bit
// [RULE_11] Record bit set updates field 0
// [RULE_12] Three immediate ops always update field 0
// [RULE_13] Field 0 from signed compare to zero
// [RULE_14] Field 0 bit 3 takes final summary overflow
// [RULE_15] Undefined result may give arbitrary flags
// [RULE_16] Field 1 never updated by float
// [RULE_17] Compare sets exactly one of lt/gt/eq
// [RULE_18] Compare bit 3 takes final summary overflow
// [RULE_19] Special registers reached by number
// [RULE_20] Branches update link register implicitly
// [RULE_21] Summary overflow forwarded in same cycle

module urf_core #(
  parameter int NUM_REGS = 32
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // Integer register ports
  input  wire logic [4:0]                   rd_addr_a,
  input  wire logic [4:0]                   rd_addr_b,
  input  wire logic                         wr_en,
  input  wire logic [4:0]                   wr_addr,
  input  wire logic [31:0]                  wr_data,
  output      logic [31:0]                  rd_data_a,
  output      logic [31:0]                  rd_data_b,
  // Condition-register operation
  input  wire urf_pkg::urf_op_t             cr_op,
  input  wire logic [7:0]                   field_mask,
  input  wire logic [2:0]                   dst_field,
  input  wire logic [2:0]                   src_field,
  input  wire logic [4:0]                   dst_bit,
  input  wire logic [4:0]                   src_bit_a,
  input  wire logic [4:0]                   src_bit_b,
  input  wire urf_pkg::urf_logic_t          logic_fn,
  input  wire logic [31:0]                  op_source,
  input  wire logic [31:0]                  cmp_second,
  input  wire logic                         cmp_unsigned,
  // Record-form result
  input  wire logic                         record_bit,
  input  wire logic                         always_record,
  input  wire logic [31:0]                  int_result,
  input  wire logic                         result_undefined,
  // Overflow update from the executing instruction
  input  wire logic                         ov_write,
  input  wire logic                         ov_value,
  input  wire logic                         ca_write,
  input  wire logic                         ca_value,
  // Branch interface
  input  wire logic [4:0]                   branch_bit,
  output      logic                         branch_cond,
  input  wire logic                         link_write,
  input  wire logic [31:0]                  link_value,
  input  wire logic                         count_dec,
  // Special-register port
  input  wire logic                         spr_wr,
  input  wire logic [9:0]                   spr_num,
  input  wire logic [31:0]                  spr_wdata,
  output      logic [31:0]                  spr_rdata,
  output      logic                         spr_hit,
  // Read-only sources
  input  wire logic [31:0]                  scratch_ro_4,
  input  wire logic [31:0]                  scratch_ro_5,
  input  wire logic [31:0]                  scratch_ro_6,
  input  wire logic [31:0]                  scratch_ro_7,
  input  wire logic [31:0]                  time_upper_word,
  input  wire logic [31:0]                  time_lower_word,
  // State
  output      logic [31:0]                  condition_flags,
  output      logic [31:0]                  fixed_point_exception,
  output      logic [31:0]                  link_return_address,
  output      logic [31:0]                  loop_count
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] integer_operand_regs [NUM_REGS];
  logic [31:0] cr_reg;
  logic [31:0] cr_next;
  logic [31:0] xer_reg;
  logic [31:0] xer_next;
  logic [31:0] lr_reg;
  logic [31:0] ctr_reg;
  logic [31:0] scratch_reg;
  logic        so_final;
  logic [3:0]  cmp_field;
  logic [3:0]  rec_field;
  logic        rec_en;
  logic        bit_a;
  logic        bit_b;
  logic        bit_res;

  // Msb-first bit index into lsb-first vector
  function automatic logic [4:0] cr_pos(input logic [4:0] n);
    cr_pos = 5'd31 - n;
  endfunction

  function automatic logic [3:0] cr_get(input logic [31:0] v, input logic [2:0] f);
    cr_get = v[(5'd28 - {f, 2'b00}) +: 4];
  endfunction

  // ----------------------------------------
  // Integer registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (wr_en) begin
      integer_operand_regs[wr_addr] <= wr_data; // [RULE_01]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_a <= `URF_RST_WORD;
      rd_data_b <= `URF_RST_WORD;
    end else begin
      rd_data_a <= integer_operand_regs[rd_addr_a];
      rd_data_b <= integer_operand_regs[rd_addr_b];
    end
  end

  // ----------------------------------------
  // Exception register
  // ----------------------------------------
  always_comb begin
    xer_next = xer_reg;
    if (spr_wr && spr_num == `URF_SPR_FIXED_POINT_EXCEPTION) begin
      xer_next = spr_wdata; // [RULE_19]
    end else if (cr_op == urf_pkg::URF_OP_MOVE_XER) begin
      xer_next[`URF_XER_TOP_NIBBLE] = 4'h0;
    end
    // Hardware set wins over a same-cycle clear
    if (ov_write) begin
      xer_next[`URF_XER_OV] = ov_value;
      if (ov_value) begin
        xer_next[`URF_XER_SO] = 1'b1;
      end
    end
    if (ca_write) begin
      xer_next[`URF_XER_CA] = ca_value;
    end
  end

  // Same-cycle forward of new summary overflow [RULE_21]
  assign so_final = xer_next[`URF_XER_SO];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xer_reg <= `URF_RST_WORD;
    end else begin
      xer_reg <= xer_next;
    end
  end

  // ----------------------------------------
  // Flag generation
  // ----------------------------------------
  urf_flag_gen u_cmp (
    .first_source_reg (op_source),
    .second_operand   (cmp_second),
    .unsigned_cmp     (cmp_unsigned),
    .summary_ovf      (so_final),
    .field_out        (cmp_field)
  );

  // Result against zero, signed; undefined results just flow through [RULE_15]
  urf_flag_gen u_rec (
    .first_source_reg (int_result),
    .second_operand   (32'h0000_0000),
    .unsigned_cmp     (1'b0),
    .summary_ovf      (so_final),
    .field_out        (rec_field)
  );

  assign rec_en = record_bit || always_record; // [RULE_11] [RULE_12]

  // ----------------------------------------
  // Condition register
  // ----------------------------------------
  always_comb begin
    bit_a = cr_reg[cr_pos(src_bit_a)];
    bit_b = cr_reg[cr_pos(src_bit_b)];
    case (logic_fn)
      urf_pkg::URF_LG_AND:  bit_res = bit_a & bit_b;
      urf_pkg::URF_LG_OR:   bit_res = bit_a | bit_b;
      urf_pkg::URF_LG_XOR:  bit_res = bit_a ^ bit_b;
      urf_pkg::URF_LG_NAND: bit_res = ~(bit_a & bit_b);
      urf_pkg::URF_LG_NOR:  bit_res = ~(bit_a | bit_b);
      urf_pkg::URF_LG_EQV:  bit_res = ~(bit_a ^ bit_b);
      urf_pkg::URF_LG_ANDC: bit_res = bit_a & ~bit_b;
      urf_pkg::URF_LG_ORC:  bit_res = bit_a | ~bit_b;
      default:              bit_res = 1'b0;
    endcase
  end

  // No float path: field 1 only moves by explicit ops [RULE_16] [RULE_02]
  always_comb begin
    cr_next = cr_reg;
    case (cr_op)
      urf_pkg::URF_OP_MOVE_FLD: begin
        for (int f = 0; f < 8; f++) begin
          if (field_mask[7 - f]) begin
            cr_next[(28 - 4 * f) +: 4] = op_source[(28 - 4 * f) +: 4]; // [RULE_05]
          end
        end
      end
      urf_pkg::URF_OP_MOVE_XER: begin
        cr_next[(5'd28 - {dst_field, 2'b00}) +: 4] =
          xer_reg[`URF_XER_TOP_NIBBLE]; // [RULE_06]
      end
      urf_pkg::URF_OP_COPY_FLD: begin
        cr_next[(5'd28 - {dst_field, 2'b00}) +: 4] = cr_get(cr_reg, src_field); // [RULE_07]
      end
      urf_pkg::URF_OP_BIT_LOGIC: begin
        cr_next[cr_pos(dst_bit)] = bit_res; // [RULE_08]
      end
      urf_pkg::URF_OP_COMPARE: begin
        cr_next[(5'd28 - {dst_field, 2'b00}) +: 4] = cmp_field; // [RULE_09] [RULE_03]
      end
      urf_pkg::URF_OP_RECORD: begin
        if (rec_en) begin
          cr_next[31:28] = rec_field; // [RULE_13] [RULE_04]
        end
      end
      default: begin
        cr_next = cr_reg;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cr_reg <= `URF_RST_WORD;
    end else begin
      cr_reg <= cr_next;
    end
  end

  // ----------------------------------------
  // Link, count and scratch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lr_reg <= `URF_RST_WORD;
    end else if (link_write) begin
      lr_reg <= link_value; // [RULE_20]
    end else if (spr_wr && spr_num == `URF_SPR_LINK_RETURN_ADDRESS) begin
      lr_reg <= spr_wdata;
    end
  end

  // Decrement wraps from zero to all ones
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctr_reg <= `URF_RST_WORD;
    end else if (count_dec) begin
      ctr_reg <= ctr_reg - 32'h0000_0001;
    end else if (spr_wr && spr_num == `URF_SPR_LOOP_COUNT) begin
      ctr_reg <= spr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scratch_reg <= `URF_RST_WORD;
    end else if (spr_wr && spr_num == `URF_SPR_USER_SCRATCH) begin
      scratch_reg <= spr_wdata;
    end
  end

  // ----------------------------------------
  // Special-register read
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spr_rdata <= `URF_RST_WORD;
      spr_hit   <= 1'b0;
    end else begin
      spr_hit <= 1'b1;
      case (spr_num) // [RULE_19]
        `URF_SPR_FIXED_POINT_EXCEPTION: spr_rdata <= xer_reg;
        `URF_SPR_LINK_RETURN_ADDRESS:   spr_rdata <= lr_reg;
        `URF_SPR_LOOP_COUNT:            spr_rdata <= ctr_reg;
        `URF_SPR_USER_SCRATCH:          spr_rdata <= scratch_reg;
        `URF_SPR_SCRATCH_RO_4:          spr_rdata <= scratch_ro_4;
        `URF_SPR_SCRATCH_RO_5:          spr_rdata <= scratch_ro_5;
        `URF_SPR_SCRATCH_RO_6:          spr_rdata <= scratch_ro_6;
        `URF_SPR_SCRATCH_RO_7:          spr_rdata <= scratch_ro_7;
        `URF_SPR_TIME_UPPER_WORD:       spr_rdata <= time_upper_word;
        `URF_SPR_TIME_LOWER_WORD:       spr_rdata <= time_lower_word;
        default: begin
          spr_rdata <= `URF_RST_WORD;
          spr_hit   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      branch_cond <= 1'b0;
    end else begin
      branch_cond <= cr_reg[cr_pos(branch_bit)]; // [RULE_10]
    end
  end

  assign condition_flags       = cr_reg;
  assign fixed_point_exception = xer_reg;
  assign link_return_address   = lr_reg;
  assign loop_count            = ctr_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_rec_field0: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_11]
    (cr_op == urf_pkg::URF_OP_RECORD && rec_en) |=> cr_reg[31:28] == $past(rec_field))
    else $error("field 0 not recorded");

  chk_norec_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_11]
    (cr_op == urf_pkg::URF_OP_RECORD && !rec_en) |=> $stable(cr_reg))
    else $error("field 0 changed without record");

  chk_cmp_onehot: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_17]
    (cr_op == urf_pkg::URF_OP_COMPARE) |=>
      $onehot(cr_get(cr_reg, $past(dst_field)) & 4'he))
    else $error("compare not one-hot");

  chk_cmp_so: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_18]
    (cr_op == urf_pkg::URF_OP_COMPARE) |=>
      cr_reg[cr_pos({$past(dst_field), 2'b11})] == xer_reg[`URF_XER_SO])
    else $error("compare overflow copy wrong");

  chk_so_fwd: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_21]
    (cr_op == urf_pkg::URF_OP_RECORD && rec_en && ov_write && ov_value) |=>
      cr_reg[28] && xer_reg[`URF_XER_SO])
    else $error("overflow not forwarded");

  chk_copy_fld: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_07]
    (cr_op == urf_pkg::URF_OP_COPY_FLD) |=>
      cr_get(cr_reg, $past(dst_field)) == cr_get($past(cr_reg), $past(src_field)))
    else $error("field copy wrong");

  chk_move_xer: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_06]
    (cr_op == urf_pkg::URF_OP_MOVE_XER && !spr_wr) |=>
      cr_get(cr_reg, $past(dst_field)) == $past(xer_reg[`URF_XER_TOP_NIBBLE]))
    else $error("exception nibble move wrong");

  chk_bit_only: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_08]
    (cr_op == urf_pkg::URF_OP_BIT_LOGIC) |=>
      ((cr_reg ^ $past(cr_reg)) & ~(32'h0000_0001 << cr_pos($past(dst_bit)))) == 32'h0)
    else $error("bit logic disturbed others");

  chk_branch_bit: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_10]
    1'b1 |=> branch_cond == $past(cr_reg[cr_pos(branch_bit)]))
    else $error("branch condition wrong");

endmodule

// ==== logic/urf_params.svh ====
`ifndef URF_PARAMS_SVH
`define URF_PARAMS_SVH

// ----------------------------------------
// Special-purpose register numbers
// ----------------------------------------
`define URF_SPR_FIXED_POINT_EXCEPTION 10'h001
`define URF_SPR_LINK_RETURN_ADDRESS   10'h008
`define URF_SPR_LOOP_COUNT            10'h009
`define URF_SPR_USER_SCRATCH          10'h100
`define URF_SPR_SCRATCH_RO_4          10'h104
`define URF_SPR_SCRATCH_RO_5          10'h105
`define URF_SPR_SCRATCH_RO_6          10'h106
`define URF_SPR_SCRATCH_RO_7          10'h107
`define URF_SPR_TIME_UPPER_WORD       10'h10c
`define URF_SPR_TIME_LOWER_WORD       10'h10d

// ----------------------------------------
// Field layout (bit 0 is the msb); exception register bits numbered lsb-first (31 is the msb)
// ----------------------------------------
`define URF_FLD_LT  0
`define URF_FLD_GT  1
`define URF_FLD_EQ  2
`define URF_FLD_SO  3
`define URF_XER_SO  31
`define URF_XER_OV  30
`define URF_XER_CA  29
`define URF_XER_TOP_NIBBLE 31:28

// ----------------------------------------
// Reset values
// ----------------------------------------
`define URF_RST_WORD  32'h0000_0000
`define URF_RST_FIELD 4'h0

`endif

// ==== logic/urf_pkg.sv ====
package urf_pkg;

  // ----------------------------------------
  // Condition-register operations
  // ----------------------------------------
  typedef enum logic [7:0] {
    URF_OP_NONE     = 8'h01,
    URF_OP_MOVE_FLD = 8'h02,
    URF_OP_MOVE_XER = 8'h04,
    URF_OP_COPY_FLD = 8'h08,
    URF_OP_BIT_LOGIC = 8'h10,
    URF_OP_COMPARE  = 8'h20,
    URF_OP_RECORD   = 8'h40,
    URF_OP_RSVD     = 8'h80
  } urf_op_t;

  // Logical function on two condition bits
  typedef enum logic [2:0] {
    URF_LG_AND  = 3'h0,
    URF_LG_OR   = 3'h1,
    URF_LG_XOR  = 3'h2,
    URF_LG_NAND = 3'h3,
    URF_LG_NOR  = 3'h4,
    URF_LG_EQV  = 3'h5,
    URF_LG_ANDC = 3'h6,
    URF_LG_ORC  = 3'h7
  } urf_logic_t;

endpackage

// ==== logic/urf_flag_gen.sv ====
`timescale 1ns/100ps
`include "urf_params.svh"

module urf_flag_gen (
  // Operands
  input  wire logic [31:0] first_source_reg,
  input  wire logic [31:0] second_operand,
  input  wire logic        unsigned_cmp,
  input  wire logic        summary_ovf,
  // Field
  output      logic [3:0]  field_out
);

  logic lt_s;
  logic lt_u;

  // Exactly one of lt, gt, eq always set [RULE_17] [RULE_13]
  always_comb begin
    lt_s = $signed(first_source_reg) < $signed(second_operand);
    lt_u = first_source_reg < second_operand;
    field_out = `URF_RST_FIELD;
    field_out[3 - `URF_FLD_LT] = unsigned_cmp ? lt_u : lt_s;
    field_out[3 - `URF_FLD_EQ] = (first_source_reg == second_operand);
    field_out[3 - `URF_FLD_GT] = !(unsigned_cmp ? lt_u : lt_s) &&
                                 (first_source_reg != second_operand);
    field_out[3 - `URF_FLD_SO] = summary_ovf; // [RULE_18] [RULE_14]
  end

endmodule

// ==== test/urf_pipe_model.sv ====
`timescale 1ns/100ps

module urf_pipe_model #(
  parameter logic [31:0] RO_BASE = 32'h5a00_0000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Read-only words seen by the core
  output      logic [31:0] scratch_ro_4,
  output      logic [31:0] scratch_ro_5,
  output      logic [31:0] scratch_ro_6,
  output      logic [31:0] scratch_ro_7,
  output      logic [31:0] time_upper_word,
  output      logic [31:0] time_lower_word
);
  // ----------------------------------------
  // Scratch and time words
  // ----------------------------------------
  logic [63:0] time_count_reg;

  // Arbitrary contents, distinct per word
  assign scratch_ro_4 = RO_BASE | 32'h0000_0004;
  assign scratch_ro_5 = RO_BASE | 32'h0000_0005;
  assign scratch_ro_6 = RO_BASE | 32'h0000_0006;
  assign scratch_ro_7 = RO_BASE | 32'h0000_0007;

  // Starts 128 counts below a carry into the upper word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      time_count_reg <= 64'h0000_0000_ffff_ff80;
    end else begin
      time_count_reg <= time_count_reg + 64'h0000_0000_0000_0001;
    end
  end

  assign time_upper_word = time_count_reg[63:32];
  assign time_lower_word = time_count_reg[31:0];
endmodule

// ==== test/tb.sv ====
`timescale 1ns/100ps
`include "urf_params.svh"

module tb;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic clk, sys_rst, wr_en, cmp_unsigned, record_bit, always_record;
  logic result_undefined, ov_write, ov_value, ca_write, ca_value;
  logic branch_cond, link_write, count_dec, spr_wr, spr_hit;
  logic [4:0] rd_addr_a, rd_addr_b, wr_addr, dst_bit, src_bit_a, src_bit_b, branch_bit;
  logic [2:0] dst_field, src_field;
  logic [7:0] field_mask;
  logic [9:0] spr_num;
  logic [31:0] wr_data, rd_data_a, rd_data_b, op_source, cmp_second, int_result;
  logic [31:0] link_value, spr_wdata, spr_rdata, condition_flags, fixed_point_exception;
  logic [31:0] link_return_address, loop_count, scratch_ro_4, scratch_ro_5;
  logic [31:0] scratch_ro_6, scratch_ro_7, time_upper_word, time_lower_word;
  urf_pkg::urf_op_t    cr_op;
  urf_pkg::urf_logic_t logic_fn;
  logic [31:0] cr_m, xer_m, a, b, w;
  logic [31:0] gpr_m [32];
  logic [31:0] ro_v [6];
  logic [9:0]  rw_n [4];
  logic [9:0]  ro_n [6];
  int          fail_count, n_checks, cyc, f, g, i, seed;

  urf_core dut (.*);
  urf_pipe_model pipe (.*);

  always #5 clk = ~clk;

  // Hang guard, well above the few hundred cycles used
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test;
    end
  end

  // ----------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Strobes drop by non-blocking update at the taking edge
  task automatic fire;
    @(posedge clk);
    cr_op <= urf_pkg::URF_OP_NONE;
    wr_en <= 1'b0;
    spr_wr <= 1'b0;
    ov_write <= 1'b0;
    ca_write <= 1'b0;
    link_write <= 1'b0;
    count_dec <= 1'b0;
    @(negedge clk);
  endtask

  task automatic spr_put(input logic [9:0] num, input logic [31:0] d);
    spr_num = num;
    spr_wdata = d;
    spr_wr = 1'b1;
    fire;
  endtask

  task automatic spr_get(input logic [9:0] num, input logic [31:0] d, input logic h);
    spr_num = num;
    fire;
    chk("spr data", d, spr_rdata);
    chk("spr hit", {31'h0, h}, {31'h0, spr_hit});
  endtask

  function automatic logic [3:0] cmp_nib(input logic [31:0] x, y, input logic u, so);
    logic lt, gt;
    lt = u ? (x < y) : ($signed(x) < $signed(y));
    gt = u ? (x > y) : ($signed(x) > $signed(y));
    return {lt, gt, x == y, so};
  endfunction

  function automatic logic lg(input urf_pkg::urf_logic_t fn, input logic x, y);
    case (fn)
      urf_pkg::URF_LG_AND:  return x & y;
      urf_pkg::URF_LG_OR:   return x | y;
      urf_pkg::URF_LG_XOR:  return x ^ y;
      urf_pkg::URF_LG_NAND: return ~(x & y);
      urf_pkg::URF_LG_NOR:  return ~(x | y);
      urf_pkg::URF_LG_EQV:  return ~(x ^ y);
      urf_pkg::URF_LG_ANDC: return x & ~y;
      default:              return x | ~y;
    endcase
  endfunction

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    seed = 32'he0d3;
    clk = 1'b0;
    sys_rst = 1'b1;
    {wr_en, cmp_unsigned, record_bit, always_record, result_undefined, ov_write} = '0;
    {ov_value, ca_write, ca_value, link_write, count_dec, spr_wr} = '0;
    {rd_addr_a, rd_addr_b, wr_addr, dst_bit, src_bit_a, src_bit_b, branch_bit} = '0;
    {dst_field, src_field, field_mask, spr_num} = '0;
    {wr_data, op_source, cmp_second, int_result, link_value, spr_wdata} = '0;
    cr_op = urf_pkg::URF_OP_NONE;
    logic_fn = urf_pkg::URF_LG_AND;
    rw_n = '{`URF_SPR_FIXED_POINT_EXCEPTION, `URF_SPR_LINK_RETURN_ADDRESS,
             `URF_SPR_LOOP_COUNT, `URF_SPR_USER_SCRATCH};
    ro_n = '{`URF_SPR_SCRATCH_RO_4, `URF_SPR_SCRATCH_RO_5, `URF_SPR_SCRATCH_RO_6,
             `URF_SPR_SCRATCH_RO_7, `URF_SPR_TIME_UPPER_WORD, `URF_SPR_TIME_LOWER_WORD};
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    cr_m = 32'h0000_0000;
    xer_m = 32'h0000_0000;
    chk("flags", cr_m, condition_flags);
    chk("xer", xer_m, fixed_point_exception);
    count_dec = 1'b1;
    fire;
    chk("count", 32'hffff_ffff, loop_count);
    link_value = $random(seed);
    link_write = 1'b1;
    fire;
    chk("link", link_value, link_return_address);
    for (i = 0; i < 32; i++) begin
      gpr_m[i] = $random(seed);
      wr_addr = i[4:0];
      wr_data = gpr_m[i];
      wr_en = 1'b1;
      fire;
    end
    for (i = 0; i < 32; i++) begin
      rd_addr_a = i[4:0];
      rd_addr_b = 5'd31 - i[4:0];
      fire;
      chk("gpr a", gpr_m[i], rd_data_a);
      chk("gpr b", gpr_m[31-i], rd_data_b);
    end
    for (i = 0; i < 24; i++) begin
      a = $random(seed);
      b = (i % 4 == 0) ? a : $random(seed);
      f = (i < 8) ? i : {$random(seed)} % 8;
      cr_op = urf_pkg::URF_OP_COMPARE;
      dst_field = f[2:0];
      op_source = a;
      cmp_second = b;
      cmp_unsigned = i[0];
      ov_write = (i == 13);
      ov_value = i[0];
      if (i == 13) xer_m[31:30] = 2'b11;
      fire;
      cr_m[31-4*f -: 4] = cmp_nib(a, b, i[0], xer_m[31]);
      chk("compare", cr_m, condition_flags);
    end
    for (i = 0; i < 4; i++) begin
      w = $random(seed);
      if (i == 0) w = w & 32'he000_007f;
      spr_put(rw_n[i], w);
      spr_get(rw_n[i], w, 1'b1);
    end
    for (i = 0; i < 6; i++) begin
      spr_put(ro_n[i], 32'hdead_0000);
      ro_v = '{scratch_ro_4, scratch_ro_5, scratch_ro_6, scratch_ro_7,
               time_upper_word, time_lower_word};
      spr_get(ro_n[i], ro_v[i], 1'b1);
    end
    spr_put(10'h3ff, 32'hffff_ffff);
    spr_get(10'h3ff, 32'h0000_0000, 1'b0);
    spr_put(`URF_SPR_FIXED_POINT_EXCEPTION, 32'h0000_0000);
    xer_m = 32'h0000_0000;
    for (i = 0; i < 18; i++) begin
      w = (i == 0) ? 32'h0 : (i == 1) ? 32'h8000_0000 : $random(seed);
      cr_op = urf_pkg::URF_OP_RECORD;
      int_result = w;
      record_bit = (i % 3 == 0);
      always_record = (i % 3 == 1);
      ov_write = (i == 10);
      ov_value = 1'b1;
      if (i == 10) xer_m[31:30] = 2'b11;
      ca_write = (i == 4);
      ca_value = 1'b1;
      if (i == 4) xer_m[29] = 1'b1;
      fire;
      if (i % 3 != 2) cr_m[31:28] = cmp_nib(w, 32'h0, 1'b0, xer_m[31]);
      chk("record", cr_m, condition_flags);
    end
    chk("xer", xer_m, fixed_point_exception);
    for (i = 0; i < 6; i++) begin
      field_mask = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      op_source = $random(seed);
      cr_op = urf_pkg::URF_OP_MOVE_FLD;
      fire;
      for (g = 0; g < 8; g++) begin
        if (field_mask[7-g]) cr_m[31-4*g -: 4] = op_source[31-4*g -: 4];
      end
      chk("move fields", cr_m, condition_flags);
    end
    for (i = 0; i < 4; i++) begin
      w = $random(seed) & 32'he000_007f;
      spr_put(`URF_SPR_FIXED_POINT_EXCEPTION, w);
      xer_m = w;
      f = {$random(seed)} % 8;
      dst_field = f[2:0];
      cr_op = urf_pkg::URF_OP_MOVE_XER;
      ov_write = (i == 0);
      fire;
      cr_m[31-4*f -: 4] = xer_m[31:28];
      xer_m[31:28] = 4'h0;
      if (i == 0) xer_m[31:30] = 2'b11;
      chk("move xer", cr_m, condition_flags);
      chk("xer", xer_m, fixed_point_exception);
    end
    for (i = 0; i < 6; i++) begin
      f = {$random(seed)} % 8;
      g = {$random(seed)} % 8;
      dst_field = f[2:0];
      src_field = g[2:0];
      cr_op = urf_pkg::URF_OP_COPY_FLD;
      fire;
      cr_m[31-4*f -: 4] = cr_m[31-4*g -: 4];
      chk("copy field", cr_m, condition_flags);
    end
    for (i = 0; i < 16; i++) begin
      logic_fn = urf_pkg::urf_logic_t'(i[2:0]);
      dst_bit = 5'($random(seed));
      src_bit_a = 5'($random(seed));
      src_bit_b = 5'($random(seed));
      cr_op = urf_pkg::URF_OP_BIT_LOGIC;
      fire;
      cr_m[31-dst_bit] = lg(logic_fn, cr_m[31-src_bit_a], cr_m[31-src_bit_b]);
      chk("bit logic", cr_m, condition_flags);
    end
    for (i = 0; i < 32; i++) begin
      branch_bit = i[4:0];
      fire;
      chk("branch", {31'h0, cr_m[31-i]}, {31'h0, branch_cond});
    end
    finish_test;
  end
endmodule
